/* File: design/mfi_pkg.sv */
// constants and types shared by the universal input counter unit
package mfi_pkg;
  localparam int NUM_IN = 4;
  localparam int NUM_CNT = 3;
  localparam int FREQ_IN = 2;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int MEAS_W = 24;
  localparam int ST_W = 9;

  // register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_CNT0 = 8'h08;
  localparam logic [7:0] ADDR_LIM0 = 8'h14;
  localparam logic [7:0] ADDR_FREQ = 8'h20;
  localparam logic [7:0] ADDR_PER = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h28;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h30;

  // configuration field positions
  localparam int MODE_FW = 3;
  localparam int EDGE_LSB = 16;
  localparam int DIR_LSB = 24;
  localparam int GATE_LSB = 28;

  // status bit positions
  localparam int ST_EDGE_LSB = 0;
  localparam int ST_CNT_LSB = 4;
  localparam int ST_FREQ = 7;
  localparam int ST_PER = 8;

  // reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [15:0] LIM_RST = 16'hFFFF;

  typedef enum logic [2:0] {
    MODE_DIG = 3'b000,
    MODE_INT = 3'b001,
    MODE_CNT = 3'b011,
    MODE_FREQ = 3'b010,
    MODE_PER = 3'b110
  } mode_t;

  localparam logic [1:0] EDGE_RISE = 2'b00;
  localparam logic [1:0] EDGE_FALL = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b10;
  localparam logic [1:0] GATE_ZERO = 2'b00;
  localparam logic [1:0] GATE_1S = 2'b01;
  localparam logic [1:0] GATE_10S = 2'b10;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 500;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int GATE_1S_S = 1;
  localparam int GATE_10S_S = 10;
  localparam int GATE_1S_CYC = GATE_1S_S * (1_000_000_000 / CLK_PERIOD_NS);
  localparam int GATE_10S_CYC = GATE_10S_S * (1_000_000_000 / CLK_PERIOD_NS);
endpackage

/* File: design/mfi_edge_detect.sv */
// input synchroniser with edge detection for one field input
`timescale 1ns/1ns
module mfi_edge_detect import mfi_pkg::*; (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, low active
  input wire logic ce, // clock enable
  input wire logic pin, // raw field input
  output logic level, // synchronised level
  output logic rise, // rising edge, one cycle
  output logic fall // falling edge, one cycle
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // two-stage synchroniser, then previous sample for edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce) begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule

/* File: design/mfi_unit.sv */
// universal input counter unit with axi4-lite register access
//
// Summary of operation
// - inputs one, two: interrupt, digital, counter
// - input three adds frequency and period modes
// - input four: interrupt or digital only
// - function chosen by host-written configuration
// - interrupt mode raises irq on selected edge
// - digital level only read by host access
// - counters catch pulses up to 10 kHz
// - each counter counts up or down
// - frequency mode counts pulses within gate time
// - period mode counts ticks between rising edges
// - up counter interrupts on reaching limit
// - down counter interrupts on reaching zero
// - gate time zero, one or ten seconds
`timescale 1ns/1ns
module mfi_unit import mfi_pkg::*; #(
  parameter int unsigned GATE_1S_CYCLES = GATE_1S_CYC,
  parameter int unsigned GATE_10S_CYCLES = GATE_10S_CYC
) (
  input wire logic CLK_SYS, // 25 MHz system clock
  input wire logic NRST, // async reset, low active
  input wire logic CE, // clock enable, freezes state when low
  input wire logic MULTI_FUNCTION_INPUT_1, // field input 1
  input wire logic MULTI_FUNCTION_INPUT_2, // field input 2
  input wire logic MULTI_FUNCTION_INPUT_3, // field input 3
  input wire logic MULTI_FUNCTION_INPUT_4, // field input 4
  output logic IRQ, // level interrupt to host
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write byte strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY // read data ready
);
  if (GATE_1S_CYCLES < 2 || GATE_10S_CYCLES < 2 || TICK_CYC < 2 || TICK_CYC > 256) begin : g_chk
    $error("gate cycle counts must be at least two, tick cycles two to 256");
  end
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] base);
    hit = (a[ADDR_W-1:2] == base[ADDR_W-1:2]);
  endfunction
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[ADDR_W-1:2] <= ADDR_IRQ_EN[ADDR_W-1:2]);
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    merge = r;
  endfunction

  // limit the raw mode field to what each input offers
  function automatic mode_t eff_mode(input int idx, input logic [2:0] raw);
    mode_t m;
    m = MODE_DIG;
    case (raw)
      MODE_INT: m = MODE_INT;
      MODE_CNT: m = (idx < NUM_CNT) ? MODE_CNT : MODE_DIG;
      MODE_FREQ: m = (idx == FREQ_IN) ? MODE_FREQ : MODE_DIG;
      MODE_PER: m = (idx == FREQ_IN) ? MODE_PER : MODE_DIG;
      default: m = MODE_DIG;
    endcase
    eff_mode = m;
  endfunction

  // ---------------- register bus ----------------
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_go;
  logic [31:0] rd_mux;
  assign S_AXI_AWREADY = CE && !aw_held_q; // nothing is taken while frozen
  assign S_AXI_WREADY = CE && !w_held_q;
  assign S_AXI_ARREADY = CE && !rvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_AWVALID && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_ARVALID && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ---------------- configuration ----------------
  logic [31:0] cfg_q;
  logic [ST_W-1:0] irq_en_q, sts_q, sts_set;
  logic [CNT_W-1:0] cnt_q [NUM_CNT];
  logic [CNT_W-1:0] lim_q [NUM_CNT];
  logic [MEAS_W-1:0] freq_res_q, per_res_q;
  logic [NUM_IN-1:0] lvl, rise, fall, ev;
  mode_t mode [NUM_IN];
  logic [1:0] gate_sel;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cfg_q <= CFG_RST;
      irq_en_q <= '0;
    end else if (CE && wr_go) begin
      if (hit(awaddr_q, ADDR_MODE)) cfg_q <= merge(cfg_q, wdata_q, wstrb_q);
      if (hit(awaddr_q, ADDR_IRQ_EN)) irq_en_q <= ST_W'(merge(32'(irq_en_q), wdata_q, wstrb_q));
    end
  end

  assign gate_sel = cfg_q[GATE_LSB +: 2];

  always_comb begin
    rd_mux = '0;
    if (hit(S_AXI_ARADDR, ADDR_MODE)) rd_mux = cfg_q;
    if (hit(S_AXI_ARADDR, ADDR_LEVEL)) rd_mux = 32'(lvl);
    if (hit(S_AXI_ARADDR, ADDR_FREQ)) rd_mux = 32'(freq_res_q);
    if (hit(S_AXI_ARADDR, ADDR_PER)) rd_mux = 32'(per_res_q);
    if (hit(S_AXI_ARADDR, ADDR_IRQ_STS)) rd_mux = 32'(sts_q);
    if (hit(S_AXI_ARADDR, ADDR_IRQ_EN)) rd_mux = 32'(irq_en_q);
    for (int k = 0; k < NUM_CNT; k++) begin
      if (hit(S_AXI_ARADDR, ADDR_CNT0 + 8'(4 * k))) rd_mux = 32'(cnt_q[k]);
      if (hit(S_AXI_ARADDR, ADDR_LIM0 + 8'(4 * k))) rd_mux = 32'(lim_q[k]);
    end
  end

  // ---------------- inputs, edge interrupts, counters ----------------
  logic [NUM_IN-1:0] pins;
  assign pins = {MULTI_FUNCTION_INPUT_4, MULTI_FUNCTION_INPUT_3, MULTI_FUNCTION_INPUT_2, MULTI_FUNCTION_INPUT_1};

  for (genvar i = 0; i < NUM_IN; i++) begin : g_in
    logic [1:0] esel;
    mfi_edge_detect u_edge (
      .clk(CLK_SYS),
      .nrst(NRST),
      .ce(CE),
      .pin(pins[i]),
      .level(lvl[i]),
      .rise(rise[i]),
      .fall(fall[i])
    );
    assign esel = cfg_q[EDGE_LSB + 2 * i +: 2];
    assign mode[i] = eff_mode(i, cfg_q[MODE_FW * i +: MODE_FW]);
    assign ev[i] = (esel == EDGE_RISE && rise[i]) || (esel == EDGE_FALL && fall[i])
                   || (esel == EDGE_BOTH && (rise[i] || fall[i]));
    assign sts_set[ST_EDGE_LSB + i] = (mode[i] == MODE_INT) && ev[i];
  end

  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    logic down, step, wr_cnt, wr_lim;
    assign down = cfg_q[DIR_LSB + i];
    assign step = (mode[i] == MODE_CNT) && ev[i];
    assign wr_cnt = wr_go && hit(awaddr_q, ADDR_CNT0 + 8'(4 * i));
    assign wr_lim = wr_go && hit(awaddr_q, ADDR_LIM0 + 8'(4 * i));
    assign sts_set[ST_CNT_LSB + i] = step && !wr_cnt
                                     && (down ? (cnt_q[i] == CNT_W'(1))
                                              : (cnt_q[i] + CNT_W'(1) == lim_q[i]));
    always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
        cnt_q[i] <= '0;
      end else if (CE) begin
        if (wr_cnt) cnt_q[i] <= CNT_W'(merge(32'(cnt_q[i]), wdata_q, wstrb_q));
        else if (step) cnt_q[i] <= down ? cnt_q[i] - CNT_W'(1) : cnt_q[i] + CNT_W'(1);
      end
    end
    always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) lim_q[i] <= LIM_RST;
      else if (CE && wr_lim) lim_q[i] <= CNT_W'(merge(32'(lim_q[i]), wdata_q, wstrb_q));
    end
  end

  // ---------------- frequency measurement ----------------
  logic [31:0] gate_q, gate_len;
  logic [MEAS_W-1:0] pcnt_q;
  logic freq_on, gate_end;
  assign freq_on = (mode[FREQ_IN] == MODE_FREQ) && (gate_sel == GATE_1S || gate_sel == GATE_10S);
  assign gate_len = (gate_sel == GATE_10S) ? GATE_10S_CYCLES : GATE_1S_CYCLES;
  assign gate_end = freq_on && (gate_q == gate_len - 32'd1);
  assign sts_set[ST_FREQ] = gate_end;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      gate_q <= '0;
      pcnt_q <= '0;
      freq_res_q <= '0;
    end else if (CE) begin
      if (!freq_on) begin
        gate_q <= '0;
        pcnt_q <= '0;
      end else if (gate_end) begin
        gate_q <= '0;
        freq_res_q <= pcnt_q;
        pcnt_q <= MEAS_W'(rise[FREQ_IN]);
      end else begin
        gate_q <= gate_q + 32'd1;
        if (rise[FREQ_IN] && pcnt_q != '1) pcnt_q <= pcnt_q + MEAS_W'(1);
      end
    end
  end

  // ---------------- period measurement ----------------
  logic [7:0] tdiv_q;
  logic [MEAS_W-1:0] tick_cnt_q;
  logic per_on, per_arm_q, tick;
  assign per_on = (mode[FREQ_IN] == MODE_PER);
  assign tick = (tdiv_q == 8'(TICK_CYC - 1));
  assign sts_set[ST_PER] = per_on && per_arm_q && rise[FREQ_IN];
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tdiv_q <= '0;
      tick_cnt_q <= '0;
      per_arm_q <= 1'b0;
      per_res_q <= '0;
    end else if (CE) begin
      if (!per_on) begin
        tdiv_q <= '0;
        tick_cnt_q <= '0;
        per_arm_q <= 1'b0;
      end else if (rise[FREQ_IN]) begin
        tdiv_q <= 8'd1; // edge cycle is the first clock of the next tick
        tick_cnt_q <= '0;
        per_arm_q <= 1'b1;
        if (per_arm_q) per_res_q <= tick_cnt_q;
      end else begin
        tdiv_q <= tick ? 8'd0 : tdiv_q + 8'd1;
        if (tick && tick_cnt_q != '1) tick_cnt_q <= tick_cnt_q + MEAS_W'(1);
      end
    end
  end

  // ---------------- interrupt status ----------------
  logic [ST_W-1:0] clr;
  assign clr = (wr_go && hit(awaddr_q, ADDR_IRQ_CLR)) ? ST_W'(wdata_q) : '0;
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) sts_q <= '0;
    else if (CE) sts_q <= (sts_q & ~clr) | sts_set; // set wins over clear
  end
  assign IRQ = |(sts_q & irq_en_q);
  // ---------------- assertions ----------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  property p_edge_irq;
    CE && mode[0] == MODE_INT && ev[0] |=> sts_q[ST_EDGE_LSB];
  endproperty
  a_edge_irq: assert property (p_edge_irq) else $error("edge interrupt not flagged");
  property p_in4_modes;
    mode[3] == MODE_DIG || mode[3] == MODE_INT;
  endproperty
  a_in4_modes: assert property (p_in4_modes) else $error("input four in counting mode");
  property p_cnt_step;
    CE && g_cnt[0].step && !g_cnt[0].wr_cnt
      |=> cnt_q[0] == ($past(cfg_q[DIR_LSB]) ? $past(cnt_q[0]) - 16'd1 : $past(cnt_q[0]) + 16'd1);
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter step wrong");
  property p_cnt_idle;
    CE && mode[1] != MODE_CNT && !g_cnt[1].wr_cnt |=> $stable(cnt_q[1]);
  endproperty
  a_cnt_idle: assert property (p_cnt_idle) else $error("idle counter moved");
  property p_up_limit;
    CE && g_cnt[0].step && !cfg_q[DIR_LSB] && !g_cnt[0].wr_cnt && cnt_q[0] + 16'd1 == lim_q[0]
      |=> sts_q[ST_CNT_LSB] && cnt_q[0] == lim_q[0];
  endproperty
  a_up_limit: assert property (p_up_limit) else $error("limit interrupt missing");
  property p_down_zero;
    CE && g_cnt[1].step && cfg_q[DIR_LSB + 1] && !g_cnt[1].wr_cnt && cnt_q[1] == 16'd1
      |=> sts_q[ST_CNT_LSB + 1] && cnt_q[1] == 16'd0;
  endproperty
  a_down_zero: assert property (p_down_zero) else $error("zero interrupt missing");
  property p_freq_latch;
    CE && gate_end |=> freq_res_q == $past(pcnt_q) && sts_q[ST_FREQ];
  endproperty
  a_freq_latch: assert property (p_freq_latch) else $error("frequency result not latched");
  property p_gate_zero;
    CE && gate_sel == GATE_ZERO |=> gate_q == 32'd0 && pcnt_q == '0;
  endproperty
  a_gate_zero: assert property (p_gate_zero) else $error("gate ran with zero gate time");
  property p_period;
    CE && per_on && per_arm_q && rise[FREQ_IN] |=> per_res_q == $past(tick_cnt_q) && tick_cnt_q == '0;
  endproperty
  a_period: assert property (p_period) else $error("period result wrong");
  property p_irq_level;
    CE && |(sts_set & irq_en_q) && !(wr_go && hit(awaddr_q, ADDR_IRQ_EN)) |=> IRQ;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("enabled event did not raise irq");
endmodule

/* File: sim/field_src.sv */
// field pulse source model driving the four multi-function inputs
`timescale 1ns/1ns
module field_src (
  input wire logic clk, // system clock
  input wire logic start, // begin a pulse train
  input wire logic [3:0] lvl, // idle level of each line
  input wire logic [3:0] mask, // lines that pulse
  input wire logic [15:0] n, // pulses per train
  input wire logic [15:0] half, // half period in clocks
  output logic [3:0] pins, // field lines
  output logic busy // train running
);
  logic ph;

  assign pins = lvl ^ (mask & {4{ph}});

  initial begin
    ph = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (start) begin
        busy <= 1'b1;
        repeat (2 * n) begin
          repeat (half) @(posedge clk); // each phase at least two clocks
          ph <= ~ph;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

/* File: sim/test_universal_input_counter_unit.sv */
// self-checking bench for the universal input counter unit
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_universal_input_counter_unit import mfi_pkg::*; ;
  localparam int G1 = 400;
  localparam int G10 = 2000;
  typedef struct packed { logic [7:0] a; logic [31:0] d; logic [1:0] r; } row_t;
  logic clk_sys, nrst, ce, irq, start, busy;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, lvl, mask, pins;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] n, half;
  int err_total, n_compared;
  row_t rows [14] = '{'{ADDR_MODE, 32'h0000_0000, RESP_OKAY}, '{ADDR_LEVEL, 32'h0000_0000, RESP_OKAY},
    '{8'h08, 32'h0000_0000, RESP_OKAY}, '{8'h0C, 32'h0000_0000, RESP_OKAY}, '{8'h10, 32'h0000_0000, RESP_OKAY},
    '{8'h14, 32'h0000_FFFF, RESP_OKAY}, '{8'h18, 32'h0000_FFFF, RESP_OKAY}, '{8'h1C, 32'h0000_FFFF, RESP_OKAY},
    '{ADDR_FREQ, 32'h0000_0000, RESP_OKAY}, '{ADDR_PER, 32'h0000_0000, RESP_OKAY},
    '{ADDR_IRQ_STS, 32'h0000_0000, RESP_OKAY}, '{ADDR_IRQ_CLR, 32'h0000_0000, RESP_OKAY},
    '{ADDR_IRQ_EN, 32'h0000_0000, RESP_OKAY}, '{8'h34, 32'h0000_0000, RESP_SLVERR}};

  field_src src (.clk(clk_sys), .start(start), .lvl(lvl), .mask(mask), .n(n), .half(half), .pins(pins),
    .busy(busy));

  mfi_unit #(.GATE_1S_CYCLES(G1), .GATE_10S_CYCLES(G10)) dut (.CLK_SYS(clk_sys), .NRST(nrst), .CE(ce),
    .MULTI_FUNCTION_INPUT_1(pins[0]), .MULTI_FUNCTION_INPUT_2(pins[1]), .MULTI_FUNCTION_INPUT_3(pins[2]),
    .MULTI_FUNCTION_INPUT_4(pins[3]), .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    r = 2'b11;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        done = 1'b1;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        done = 1'b1;
        rready <= 1'b0;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rs);
  endtask

  task automatic rd_is(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rs);
    `CHK(rd, exp)
  endtask

  task automatic train(input logic [3:0] m, input logic [15:0] cnt, input logic [15:0] h);
    @(posedge clk_sys);
    mask <= m;
    n <= cnt;
    half <= h;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
  endtask

  task automatic wait_src();
    @(posedge clk_sys);
    while (busy) @(posedge clk_sys);
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic wait_sts(input int b);
    int k;
    k = 0;
    rd = '0;
    while (rd[b] !== 1'b1 && k < 2000) begin
      axi_rd(ADDR_IRQ_STS, rd, rs);
      k++;
    end
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, start} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    lvl = 4'h0;
    mask = 4'h0;
    n = 16'h0000;
    half = 16'h0002;
    err_total = 0;
    n_compared = 0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      axi_rd(rows[i].a, rd, rs);
      `CHK(rd, rows[i].d)
      `CHK(rs, rows[i].r)
    end
    // digital mode: level readable, no events
    lvl <= 4'b1010;
    repeat (6) @(posedge clk_sys);
    rd_is(ADDR_LEVEL, 32'h0000_000A);
    rd_is(ADDR_IRQ_STS, 32'h0000_0000);
    lvl <= 4'b0000;
    repeat (6) @(posedge clk_sys);
    // interrupt mode: rise, fall, both, rise
    wr(ADDR_MODE, 32'h0024_0249);
    wr(ADDR_IRQ_CLR, 32'h0000_01FF);
    wr(ADDR_IRQ_EN, 32'h0000_000F);
    lvl <= 4'b1111;
    repeat (8) @(posedge clk_sys);
    rd_is(ADDR_IRQ_STS, 32'h0000_000D);
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_EN, 32'h0000_0000);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_CLR, 32'h0000_000D);
    rd_is(ADDR_IRQ_STS, 32'h0000_0000);
    lvl <= 4'b0000;
    repeat (8) @(posedge clk_sys);
    rd_is(ADDR_IRQ_STS, 32'h0000_0006);
    // counters at 10 kHz: 1 up to limit, 2 down through zero, 3 up; input 4 cannot count
    wr(ADDR_MODE, 32'h0200_06DB);
    wr(ADDR_LIM0, 32'h0000_0005);
    wr(8'h0C, 32'h0000_0003);
    wr(ADDR_IRQ_CLR, 32'h0000_01FF);
    train(4'hF, 16'd5, 16'd1250);
    wait_src();
    rd_is(ADDR_CNT0, 32'h0000_0005);
    rd_is(8'h0C, 32'h0000_FFFE);
    rd_is(8'h10, 32'h0000_0005);
    rd_is(ADDR_IRQ_STS, 32'h0000_0030);
    rd_is(ADDR_PER, 32'h0000_0000);
    // clock enable low: a pulse on input 1 is not seen
    ce <= 1'b0;
    lvl <= 4'b0001;
    repeat (6) @(posedge clk_sys);
    lvl <= 4'b0000;
    repeat (6) @(posedge clk_sys);
    ce <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd_is(ADDR_CNT0, 32'h0000_0005);
    // period mode on input 3: 120 clocks between rising edges
    wr(ADDR_MODE, 32'h0000_0180);
    wr(ADDR_IRQ_CLR, 32'h0000_01FF);
    train(4'b0100, 16'd3, 16'd60);
    wait_src();
    rd_is(ADDR_PER, 32'(120 / TICK_CYC));
    rd_is(ADDR_IRQ_STS, 32'h0000_0100);
    // frequency mode: steady train of period 8 clocks, both gate settings
    train(4'b0100, 16'd1000, 16'd4);
    for (int g = 1; g < 3; g++) begin
      wr(ADDR_MODE, 32'h0000_0080 | (32'(g) << GATE_LSB));
      wr(ADDR_IRQ_CLR, 32'h0000_01FF);
      wait_sts(ST_FREQ);
      wr(ADDR_IRQ_CLR, 32'h0000_01FF);
      wait_sts(ST_FREQ);
      `CHK(rd[ST_FREQ], 1'b1)
      rd_is(ADDR_FREQ, 32'((g == 1 ? G1 : G10) / 8));
    end
    wr(ADDR_MODE, 32'h0000_0080);
    wr(ADDR_IRQ_CLR, 32'h0000_01FF);
    repeat (600) @(posedge clk_sys);
    rd_is(ADDR_IRQ_STS, 32'h0000_0000);
    wait_src();
    axi_wr(8'h34, 32'h1234_5678, rs);
    `CHK(rs, RESP_SLVERR)
    // byte strobes: only lane 1 of the limit changes
    wstrb <= 4'h2;
    wr(ADDR_LIM0, 32'h0000_3400);
    wstrb <= 4'hF;
    rd_is(ADDR_LIM0, 32'h0000_3405);
    // second reset in mid-run
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK({awready, wready, arready, bvalid, rvalid, irq}, 6'h38)
    nrst <= 1'b1;
    rd_is(ADDR_MODE, 32'h0000_0000);
    rd_is(ADDR_CNT0, 32'h0000_0000);
    wrap_up();
  end
endmodule
